//--- rtl/pdm_pkg.sv
// Constants shared by the divider and modulator configuration registers.
// Functional notes
// R01: Reference divider is 14 bits, 1 to 16383.
// R02: Host also enables reference buffer elsewhere.
// R03: Integer word 19 bits, mode-dependent legal range.
// R04: Fractional word adds value over 2^24.
// R05: Indirect word: id, address, nine data bits.
// R06: Indirect writes forwarded by a state machine.
// R07: Indirect readback shows last forwarded word only.
// R08: Seed select picks zero, one, two constants.
// R09: Seed staged, loaded on frequency change if autoload.
// R10: Skip bit ignores modulator output for integer.
// R11: Skipped modulator still clocked while out of reset.
// R12: Core enable bit switches fractional core.
// R13: Core enable picks which write starts calibration.
// R14: Write to selected word is frequency change.
// R15: 32-bit frame committed on serial enable rise.
package pdm_pkg;

   // Register addresses carried in the serial frame.
   localparam logic [4:0]  ADDR_REF_DIV   = 5'h02;
   localparam logic [4:0]  ADDR_INT_WORD  = 5'h03;
   localparam logic [4:0]  ADDR_FRAC_WORD = 5'h04;
   localparam logic [4:0]  ADDR_VCO_IND   = 5'h05;
   localparam logic [4:0]  ADDR_MOD_CFG   = 5'h06;

   // Values after reset.
   localparam logic [13:0] RST_REF_DIV    = 14'h0001;
   localparam logic [18:0] RST_INT_WORD   = 19'h00019;
   localparam logic [23:0] RST_FRAC_WORD  = 24'h000000;
   localparam logic [15:0] RST_VCO_IND    = 16'h0000;
   localparam logic [23:0] RST_MOD_CFG    = 24'h200b4a;

   // Legal ranges of the integer divide word in the two modes.
   localparam logic [18:0] INT_MIN_FRAC   = 19'h00014;
   localparam logic [18:0] INT_MAX_FRAC   = 19'h7fffc;
   localparam logic [18:0] INT_MIN_INT    = 19'h00010;

   // Field positions inside the modulator configuration register.
   localparam int          FB_SEED_LO     = 0;
   localparam int          FB_SKIP        = 7;
   localparam int          FB_AUTOLOAD    = 8;
   localparam int          FB_CORE_EN     = 11;

   // Fixed modulator start words.
   localparam logic [23:0] SEED_ZERO      = 24'h000000;
   localparam logic [23:0] SEED_LSB       = 24'h000001;
   localparam logic [23:0] SEED_CONST_A   = 24'hb29d08;
   localparam logic [23:0] SEED_CONST_B   = 24'h50f1cd;

   // Serial frame layout.
   localparam logic [5:0]  FRAME_BITS     = 6'h20;
   localparam logic [2:0]  CHIP_ADDR      = 3'h0;
   localparam int          FRM_DATA_LO    = 8;
   localparam int          FRM_ADDR_LO    = 3;

   // Indirect word layout and forwarding link timing.
   localparam int          VI_ID_LO       = 0;
   localparam int          VI_ADDR_LO     = 3;
   localparam int          VI_DATA_LO     = 7;
   localparam logic [4:0]  VI_BITS        = 5'h10;
   localparam logic [3:0]  VI_HALF_CYCLES = 4'h2;

endpackage : pdm_pkg

//--- rtl/pdm_vco_fwd.sv
// Serial forwarder that carries one indirect word to the VCO subsystem.
`timescale 1ns/10ps
module pdm_vco_fwd
   import pdm_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Request.
   input  wire logic        start,
   input  wire logic [15:0] word,
   output logic             busy,
   // Subsystem link.
   output logic             vco_clk,
   output logic             vco_data,
   output logic             vco_load
);

   typedef enum logic [1:0] {FW_IDLE, FW_SHIFT, FW_LOAD} pdm_fw_state_t;

   pdm_fw_state_t state, next_state;
   logic [15:0]   sr, next_sr;
   logic [4:0]    bits, next_bits;
   logic [3:0]    div, next_div;
   logic          next_vco_clk;
   logic          next_vco_data;
   logic          next_vco_load;

   // Shifts the word out MSB first, data then address then id, then pulses load.
   always_comb begin
      next_state    = state;
      next_sr       = sr;
      next_bits     = bits;
      next_div      = div;
      next_vco_clk  = vco_clk;
      next_vco_data = vco_data;
      next_vco_load = 1'b0;
      case (state)
         FW_IDLE: begin
            if (start) begin // [R06]
               next_sr       = {word[14:0], 1'b0};
               next_vco_data = word[15];
               next_bits     = VI_BITS;
               next_div      = VI_HALF_CYCLES;
               next_state    = FW_SHIFT;
            end
         end
         FW_SHIFT: begin
            if (div > 4'h1) begin
               next_div = div - 4'h1;
            end else begin
               next_div     = VI_HALF_CYCLES;
               next_vco_clk = ~vco_clk;
               if (vco_clk) begin
                  // Falling edge moves to the next bit.
                  next_bits     = bits - 5'h01;
                  next_vco_data = sr[15];
                  next_sr       = {sr[14:0], 1'b0};
                  if (bits == 5'h01) begin
                     next_state = FW_LOAD;
                  end
               end
            end
         end
         FW_LOAD: begin
            next_vco_load = 1'b1;
            next_vco_data = 1'b0;
            next_state    = FW_IDLE;
         end
         default: begin
            next_state = FW_IDLE;
         end
      endcase
   end

   // Registers the forwarder state.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state    <= FW_IDLE;
         sr       <= 16'h0000;
         bits     <= 5'h00;
         div      <= 4'h0;
         vco_clk  <= 1'b0;
         vco_data <= 1'b0;
         vco_load <= 1'b0;
         busy     <= 1'b0;
      end else if (ce) begin
         state    <= next_state;
         sr       <= next_sr;
         bits     <= next_bits;
         div      <= next_div;
         vco_clk  <= next_vco_clk;
         vco_data <= next_vco_data;
         vco_load <= next_vco_load;
         busy     <= (next_state != FW_IDLE);
      end
   end

endmodule // pdm_vco_fwd

//--- rtl/pdm_regs.sv
// Divider and delta-sigma modulator configuration registers behind the serial port.
`timescale 1ns/10ps
module pdm_regs
   import pdm_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   // Serial port pins.
   input  wire logic        SERIAL_CLK,
   input  wire logic        SERIAL_DATA_IN,
   input  wire logic        SERIAL_ENABLE,
   // Readback selection from the read address logic, and its data.
   input  wire logic [4:0]  READ_SEL,
   output logic      [23:0] RD_DATA,
   // Divider settings.
   output logic      [13:0] REF_DIV,
   output logic      [18:0] INT_WORD,
   output logic      [23:0] FRAC_WORD,
   output logic             DIV_RANGE_ERR,
   // Modulator controls.
   output logic      [23:0] MOD_SEED,
   output logic             MOD_SEED_LOAD,
   output logic             MOD_SKIP,
   output logic             MOD_RST_N,
   output logic             MOD_CLK_EN,
   output logic             CAL_START,
   // VCO subsystem link.
   output logic             VCO_CLK,
   output logic             VCO_DATA,
   output logic             VCO_LOAD
);

   // Pin synchronisers and edge history.
   logic       sclk_s1, sclk_s2, sclk_d;
   logic       sdi_s1, sdi_s2;
   logic       sen_s1, sen_s2, sen_d;
   logic       sclk_rise, sen_rise;

   // Frame capture.
   logic [31:0] sr, next_sr;
   logic [5:0]  cnt, next_cnt;
   logic        commit;
   logic [23:0] wdata;
   logic [4:0]  waddr;

   // Register contents.
   logic [13:0] ref_div, next_ref_div;
   logic [18:0] int_word, next_int_word;
   logic [23:0] frac_word, next_frac_word;
   logic [15:0] vco_word, next_vco_word;
   logic [15:0] pend_word, next_pend_word;
   logic        pend, next_pend;
   logic        fwd_start, next_fwd_start;
   logic        fwd_busy;
   logic [23:0] mod_cfg, next_mod_cfg;
   logic [23:0] next_seed;
   logic        freq_evt;
   logic [23:0] seed_pick;
   logic [23:0] next_rd;
   logic        next_range_err;

   // Two flip-flops on every pin, a third on clock and enable for edge detection.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
         sen_s1  <= 1'b1;
         sen_s2  <= 1'b1;
         sen_d   <= 1'b1;
      end else if (CE) begin
         sclk_s1 <= SERIAL_CLK;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         sdi_s1  <= SERIAL_DATA_IN;
         sdi_s2  <= sdi_s1;
         sen_s1  <= SERIAL_ENABLE;
         sen_s2  <= sen_s1;
         sen_d   <= sen_s2;
      end
   end

   assign sclk_rise = sclk_s2 & ~sclk_d;
   assign sen_rise  = sen_s2 & ~sen_d;

   // Shifts bits while the enable is low; the frame is taken on its rise.
   always_comb begin
      next_sr  = sr;
      next_cnt = cnt;
      if (sen_rise) begin
         next_cnt = 6'h00;
      end else if (!sen_s2 && sclk_rise) begin
         next_sr = {sr[30:0], sdi_s2};
         if (cnt != 6'h3f) begin
            next_cnt = cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         sr  <= 32'h00000000;
         cnt <= 6'h00;
      end else if (CE) begin
         sr  <= next_sr;
         cnt <= next_cnt;
      end
   end

   // Exactly 32 bits and a matching chip address make a write.
   assign commit = sen_rise && (cnt == FRAME_BITS) && (sr[2:0] == CHIP_ADDR); // [R15]
   assign wdata  = sr[31:FRM_DATA_LO];
   assign waddr  = sr[FRM_DATA_LO-1:FRM_ADDR_LO];

   // The write to the word chosen by core enable is the frequency change.
   assign freq_evt = commit && (mod_cfg[FB_CORE_EN] ? (waddr == ADDR_FRAC_WORD)  // [R13] [R14]
                                                    : (waddr == ADDR_INT_WORD));

   // Start word picked by the staged seed select code.
   always_comb begin
      case (mod_cfg[FB_SEED_LO+1:FB_SEED_LO]) // [R08]
         2'h0:    seed_pick = SEED_ZERO;
         2'h1:    seed_pick = SEED_LSB;
         2'h2:    seed_pick = SEED_CONST_A;
         default: seed_pick = SEED_CONST_B;
      endcase
   end

   // Register writes, indirect forwarding requests and seed loading.
   always_comb begin
      next_ref_div   = ref_div;
      next_int_word  = int_word;
      next_frac_word = frac_word;
      next_mod_cfg   = mod_cfg;
      next_vco_word  = vco_word;
      next_pend_word = pend_word;
      next_pend      = pend;
      next_fwd_start = 1'b0;
      next_seed      = MOD_SEED;
      // A waiting word is handed over once the forwarder is free.
      if (pend && !fwd_busy && !fwd_start) begin
         next_fwd_start = 1'b1; // [R06]
         next_pend      = 1'b0;
         next_vco_word  = pend_word; // [R07]
      end
      if (commit) begin
         case (waddr)
            ADDR_REF_DIV: begin
               // Zero is not a legal divide value and is taken as one.
               next_ref_div = (wdata[13:0] == 14'h0000) ? RST_REF_DIV : wdata[13:0]; // [R01]
            end
            ADDR_INT_WORD: begin
               next_int_word = wdata[18:0]; // [R03]
            end
            ADDR_FRAC_WORD: begin
               next_frac_word = wdata; // [R04]
            end
            ADDR_VCO_IND: begin
               // A new write wins over the hand-over in the same cycle.
               next_pend_word = wdata[15:0]; // [R05]
               next_pend      = 1'b1; // [R06]
            end
            ADDR_MOD_CFG: begin
               next_mod_cfg = wdata;
            end
            default: begin
               next_mod_cfg = mod_cfg;
            end
         endcase
      end
      if (freq_evt && mod_cfg[FB_AUTOLOAD]) begin
         next_seed = seed_pick; // [R09]
      end
   end

   // Integer word legality depends on the mode in force.
   always_comb begin
      if (next_mod_cfg[FB_SKIP]) begin
         next_range_err = (next_int_word < INT_MIN_INT); // [R03]
      end else begin
         next_range_err = (next_int_word < INT_MIN_FRAC) || (next_int_word > INT_MAX_FRAC);
      end
   end

   // Readback multiplexer; unmapped addresses read as zero.
   always_comb begin
      case (READ_SEL)
         ADDR_REF_DIV:   next_rd = {10'h000, ref_div};
         ADDR_INT_WORD:  next_rd = {5'h00, int_word};
         ADDR_FRAC_WORD: next_rd = frac_word;
         ADDR_VCO_IND:   next_rd = {8'h00, vco_word}; // [R07]
         ADDR_MOD_CFG:   next_rd = mod_cfg;
         default:        next_rd = 24'h000000;
      endcase
   end

   // Registers the configuration and every top-level output except the VCO link, which the forwarder drives.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         ref_div       <= RST_REF_DIV;
         int_word      <= RST_INT_WORD;
         frac_word     <= RST_FRAC_WORD;
         mod_cfg       <= RST_MOD_CFG;
         vco_word      <= RST_VCO_IND;
         pend_word     <= RST_VCO_IND;
         pend          <= 1'b0;
         fwd_start     <= 1'b0;
         RD_DATA       <= 24'h000000;
         REF_DIV       <= RST_REF_DIV;
         INT_WORD      <= RST_INT_WORD;
         FRAC_WORD     <= RST_FRAC_WORD;
         DIV_RANGE_ERR <= 1'b0;
         MOD_SEED      <= SEED_ZERO;
         MOD_SEED_LOAD <= 1'b0;
         MOD_SKIP      <= 1'b0;
         MOD_RST_N     <= 1'b0;
         MOD_CLK_EN    <= 1'b0;
         CAL_START     <= 1'b0;
      end else if (CE) begin
         ref_div       <= next_ref_div;
         int_word      <= next_int_word;
         frac_word     <= next_frac_word;
         mod_cfg       <= next_mod_cfg;
         vco_word      <= next_vco_word;
         pend_word     <= next_pend_word;
         pend          <= next_pend;
         fwd_start     <= next_fwd_start;
         RD_DATA       <= next_rd;
         REF_DIV       <= next_ref_div;
         INT_WORD      <= next_int_word;
         // Fraction counts only while the modulator output is used.
         FRAC_WORD     <= next_mod_cfg[FB_SKIP] ? 24'h000000 : next_frac_word; // [R04] [R10]
         DIV_RANGE_ERR <= next_range_err;
         MOD_SEED      <= next_seed;
         MOD_SEED_LOAD <= freq_evt && mod_cfg[FB_AUTOLOAD]; // [R09]
         MOD_SKIP      <= next_mod_cfg[FB_SKIP]; // [R10]
         MOD_RST_N     <= next_mod_cfg[FB_CORE_EN]; // [R12]
         // Clocking follows the core reset, not the skip bit.
         MOD_CLK_EN    <= next_mod_cfg[FB_CORE_EN]; // [R11]
         CAL_START     <= freq_evt; // [R13]
      end
   end

   // Forwarder to the VCO subsystem.
   pdm_vco_fwd u_fwd (
      .clk      (SYS_CLK),
      .rst_n    (NRST),
      .ce       (CE),
      .start    (fwd_start),
      .word     (vco_word), // The word sent is the one that reads back. [R07]
      .busy     (fwd_busy),
      .vco_clk  (VCO_CLK),
      .vco_data (VCO_DATA),
      .vco_load (VCO_LOAD)
   );

   // Checks on the register behaviour.
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   chk_refdiv_nonzero: assert property (REF_DIV != 14'h0000) // [R01]
      else $error("Reference divider output is zero.");

   chk_int_range_flag: assert property (CE && !next_mod_cfg[FB_SKIP] && next_int_word < INT_MIN_FRAC // [R03]
                                        |=> DIV_RANGE_ERR)
      else $error("Low integer word not flagged in fractional mode.");

   chk_frac_skip_zero: assert property (CE && next_mod_cfg[FB_SKIP] |=> FRAC_WORD == 24'h000000) // [R04]
      else $error("Fraction applied while modulator is skipped.");

   chk_vco_forward: assert property (CE && commit && waddr == ADDR_VCO_IND // [R06]
                                     |-> ##[1:300] VCO_LOAD)
      else $error("Indirect write was not forwarded.");

   chk_vco_readback: assert property (CE && pend && !fwd_busy && !fwd_start // [R07]
                                      |=> fwd_start && vco_word == $past(pend_word) ##1 fwd_busy)
      else $error("Readback does not hold the forwarded word.");

   chk_seed_const_b: assert property (CE && freq_evt && mod_cfg[FB_AUTOLOAD] // [R08]
                                      && mod_cfg[1:0] == 2'h3 |=> MOD_SEED == SEED_CONST_B && MOD_SEED_LOAD)
      else $error("Seed constant not loaded.");

   chk_seed_staged: assert property (!(freq_evt && mod_cfg[FB_AUTOLOAD]) |=> $stable(MOD_SEED)) // [R09]
      else $error("Seed changed without a frequency change.");

   chk_skipped_clock: assert property (MOD_RST_N |-> MOD_CLK_EN) // [R11]
      else $error("Modulator out of reset but not clocked.");

   chk_skip_core_out: assert property (CE |=> MOD_SKIP == $past(next_mod_cfg[FB_SKIP]) // [R10] [R12]
                                           && MOD_RST_N == $past(next_mod_cfg[FB_CORE_EN]))
      else $error("Modulator controls do not follow the configuration.");

   chk_cal_source: assert property (CE && commit && waddr == ADDR_INT_WORD && mod_cfg[FB_CORE_EN] // [R13]
                                    |=> !CAL_START)
      else $error("Calibration started by the wrong word.");

   chk_short_frame: assert property (CE && sen_rise && cnt != FRAME_BITS |=> $stable(int_word) // [R15]
                                     && $stable(mod_cfg))
      else $error("Short frame changed a register.");

   cov_freq_change: cover property (freq_evt && mod_cfg[FB_AUTOLOAD]);
   cov_vco_load:    cover property (VCO_LOAD);
   cov_back_to_back: cover property (pend && fwd_busy);
   cov_integer_mode: cover property (MOD_SKIP && CAL_START);

endmodule // pdm_regs

//--- tb/pdm_host_model.sv
// Host controller model that sends write frames on the serial port pins.
`timescale 1ns/10ps
module pdm_host_model
   import pdm_pkg::*;
(
   // Clock.
   input  wire logic clk,
   // Serial port pins.
   output logic      serial_clk,
   output logic      serial_data_in,
   output logic      serial_enable
);

   // Pins start idle: clock still, enable high.
   initial begin
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
      serial_enable  = 1'b1;
   end

   // Sends the top nbits of a frame MSB first, four cycles per clock level.
   task automatic send(input logic [31:0] frm, input int nbits);
      int i;
      @(posedge clk);
      serial_enable <= 1'b0;
      for (i = 31; i > 31 - nbits; i--) begin
         serial_data_in <= frm[i];
         repeat (4) @(posedge clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge clk);
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      // Commit on the enable rise; the released data line shows the inverse of its last bit.
      serial_enable  <= 1'b1;
      serial_data_in <= ~serial_data_in;
      repeat (12) @(posedge clk);
   endtask

endmodule // pdm_host_model

//--- tb/pdm_regs_tb.sv
// Self-checking testbench of the divider and modulator configuration registers.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pdm_regs_tb;
   import pdm_pkg::*;

   logic        SYS_CLK = 1'b0;
   logic        NRST = 1'b0;
   logic        CE = 1'b1;
   logic        SERIAL_CLK, SERIAL_DATA_IN, SERIAL_ENABLE;
   logic [4:0]  READ_SEL = 5'h00;
   logic [23:0] RD_DATA, FRAC_WORD, MOD_SEED;
   logic [13:0] REF_DIV;
   logic [18:0] INT_WORD;
   logic        DIV_RANGE_ERR, MOD_SEED_LOAD, MOD_SKIP, MOD_RST_N, MOD_CLK_EN, CAL_START;
   logic        VCO_CLK, VCO_DATA, VCO_LOAD, vclk_q = 1'b0;
   logic [15:0] vsh = 16'h0000, vword = 16'h0000;
   int          fails = 0, tests_run = 0, cal_cnt = 0, seed_cnt = 0, vcnt = 0, c;
   logic [23:0] seeds [4] = '{SEED_ZERO, SEED_LSB, SEED_CONST_A, SEED_CONST_B};
   logic [23:0] rst_tab [5] = '{24'h000001, 24'h000019, 24'h000000, 24'h000000, 24'h200b4a};

   // The clock runs at 250 MHz.
   always #2 SYS_CLK = ~SYS_CLK;

   pdm_regs i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .SERIAL_CLK(SERIAL_CLK),
      .SERIAL_DATA_IN(SERIAL_DATA_IN), .SERIAL_ENABLE(SERIAL_ENABLE), .READ_SEL(READ_SEL),
      .RD_DATA(RD_DATA), .REF_DIV(REF_DIV), .INT_WORD(INT_WORD), .FRAC_WORD(FRAC_WORD),
      .DIV_RANGE_ERR(DIV_RANGE_ERR), .MOD_SEED(MOD_SEED), .MOD_SEED_LOAD(MOD_SEED_LOAD),
      .MOD_SKIP(MOD_SKIP), .MOD_RST_N(MOD_RST_N), .MOD_CLK_EN(MOD_CLK_EN), .CAL_START(CAL_START),
      .VCO_CLK(VCO_CLK), .VCO_DATA(VCO_DATA), .VCO_LOAD(VCO_LOAD));

   pdm_host_model i_host (.clk(SYS_CLK), .serial_clk(SERIAL_CLK), .serial_data_in(SERIAL_DATA_IN),
      .serial_enable(SERIAL_ENABLE));

   // Counts pulse cycles, shifts in a VCO link bit at each clock rise and keeps the word on load.
   always_ff @(posedge SYS_CLK) begin
      if (CAL_START === 1'b1) cal_cnt <= cal_cnt + 1;
      if (MOD_SEED_LOAD === 1'b1) seed_cnt <= seed_cnt + 1;
      vclk_q <= VCO_CLK;
      if (VCO_CLK === 1'b1 && vclk_q === 1'b0) vsh <= {vsh[14:0], VCO_DATA};
      if (VCO_LOAD === 1'b1) begin
         vword <= vsh;
         vcnt  <= vcnt + 1;
      end
   end

   // Builds a modulator configuration word with the reserved fields at their reset values.
   function automatic logic [23:0] cfg(logic core, logic al, logic skip, logic [1:0] code);
      return {12'h200, core, 2'b01, al, skip, 5'h12, code};
   endfunction

   // One register write frame with chip address zero.
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      i_host.send({d, a, CHIP_ADDR}, 32);
   endtask

   // Selects a register for readback and compares the data.
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      @(posedge SYS_CLK);
      READ_SEL <= a;
      repeat (2) @(posedge SYS_CLK);
      #1 `CHK("rd_data", e, RD_DATA)
   endtask

   // Waits a bounded time for the given number of forwarded words.
   task automatic wait_vco(input int n);
      int k;
      for (k = 0; k < 300 && vcnt < n; k++) @(posedge SYS_CLK);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog well past the expected length of the sequence.
   initial begin
      repeat (40000) @(posedge SYS_CLK);
      fails++;
      conclude();
   end

   // Main sequence.
   initial begin
      repeat (6) @(posedge SYS_CLK);
      NRST <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      for (c = 0; c < 5; c++) rd(ADDR_REF_DIV + 5'(c), rst_tab[c]);
      rd(5'h07, 24'h000000);
      `CHK("mod_rst_n", 1'b1, MOD_RST_N)
      `CHK("mod_skip", 1'b0, MOD_SKIP)
      // Reference divider: top value, zero, wrong chip address, short frame.
      wr(ADDR_REF_DIV, 24'hff3fff);
      `CHK("ref_div", 14'h3fff, REF_DIV)
      wr(ADDR_REF_DIV, 24'h000000);
      `CHK("ref_div", 14'h0001, REF_DIV)
      i_host.send({24'h000abc, ADDR_REF_DIV, 3'h1}, 32);
      i_host.send({24'h000055, ADDR_REF_DIV, 3'h0} << 1, 31);
      `CHK("ref_div", 14'h0001, REF_DIV)
      // The host enables the reference buffer in a register outside this block, which ignores it.
      wr(5'h08, 24'h000008);
      rd(5'h08, 24'h000000);
      `CHK("ref_div", 14'h0001, REF_DIV)
      // A frame sent while the clock enable is low is never seen.
      CE <= 1'b0;
      wr(ADDR_REF_DIV, 24'h000abc);
      CE <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      `CHK("ref_div", 14'h0001, REF_DIV)
      // Every seed code loads on a fractional write with core enable and autoload set.
      for (c = 0; c < 4; c++) begin
         wr(ADDR_MOD_CFG, cfg(1'b1, 1'b1, 1'b0, c[1:0]));
         wr(ADDR_FRAC_WORD, 24'hc00100 + 24'(c));
         `CHK("frac_word", 24'hc00100 + 24'(c), FRAC_WORD)
         `CHK("mod_seed", seeds[c], MOD_SEED)
         `CHK("seed_loads", c + 1, seed_cnt)
         `CHK("cal_starts", c + 1, cal_cnt)
      end
      // Autoload clear: calibration starts but the seed stays.
      wr(ADDR_MOD_CFG, cfg(1'b1, 1'b0, 1'b0, 2'b00));
      wr(ADDR_FRAC_WORD, 24'h000777);
      `CHK("seed_loads", 4, seed_cnt)
      `CHK("mod_seed", SEED_CONST_B, MOD_SEED)
      `CHK("cal_starts", 5, cal_cnt)
      wr(ADDR_INT_WORD, 24'h000014);
      `CHK("int_word", 19'h00014, INT_WORD)
      `CHK("range_err", 1'b0, DIV_RANGE_ERR)
      `CHK("cal_starts", 5, cal_cnt)
      // Core enable clear: the integer write becomes the frequency change.
      wr(ADDR_MOD_CFG, cfg(1'b0, 1'b0, 1'b0, 2'b00));
      `CHK("mod_rst_n", 1'b0, MOD_RST_N)
      `CHK("mod_clk_en", 1'b0, MOD_CLK_EN)
      wr(ADDR_INT_WORD, 24'h000010);
      `CHK("cal_starts", 6, cal_cnt)
      wr(ADDR_FRAC_WORD, 24'h000888);
      `CHK("cal_starts", 6, cal_cnt)
      // Skip with core enabled: output ignored, modulator still clocked.
      wr(ADDR_MOD_CFG, cfg(1'b1, 1'b0, 1'b1, 2'b00));
      `CHK("mod_skip", 1'b1, MOD_SKIP)
      `CHK("frac_word", 24'h000000, FRAC_WORD)
      `CHK("mod_clk_en", 1'b1, MOD_CLK_EN)
      `CHK("range_err", 1'b0, DIV_RANGE_ERR)
      wr(ADDR_MOD_CFG, cfg(1'b1, 1'b0, 1'b0, 2'b01));
      `CHK("range_err", 1'b1, DIV_RANGE_ERR)
      wr(ADDR_INT_WORD, 24'h07fffd);
      `CHK("range_err", 1'b1, DIV_RANGE_ERR)
      wr(ADDR_INT_WORD, 24'h07fffc);
      `CHK("range_err", 1'b0, DIV_RANGE_ERR)
      // Indirect writes reach the VCO link MSB first and read back as forwarded.
      wr(ADDR_VCO_IND, 24'hff1234);
      wait_vco(1);
      `CHK("vco_word", 16'h1234, vword)
      wr(ADDR_VCO_IND, 24'h00abcd);
      wait_vco(2);
      `CHK("vco_word", 16'habcd, vword)
      `CHK("vco_count", 2, vcnt)
      rd(ADDR_VCO_IND, 24'h00abcd);
      wr(ADDR_REF_DIV, 24'h000123);
      rd(ADDR_REF_DIV, 24'h000123);
      rd(ADDR_INT_WORD, 24'h07fffc);
      rd(ADDR_FRAC_WORD, 24'h000888);
      rd(ADDR_MOD_CFG, cfg(1'b1, 1'b0, 1'b0, 2'b01));
      conclude();
   end

endmodule // pdm_regs_tb
